// file: pkg/lp_ctrl_pkg.sv
// Types for the core low-power state controller
`include "lp_ctrl_regs.svh"

package lp_ctrl_pkg;

	// Controller states
	typedef enum logic [3:0] {
		ST_NORMAL = 4'h0,
		ST_HALT = 4'h1,
		ST_HALT_SNOOP = 4'h2,
		ST_XH_RATIO_DN = 4'h3,
		ST_XH_VSEL_DN = 4'h4,
		ST_XHALT = 4'h5,
		ST_XH_SNOOP = 4'h6,
		ST_XH_VSEL_UP = 4'h7,
		ST_XH_RATIO_UP = 4'h8,
		ST_SG_ACK = 4'h9,
		ST_SG_COUNT = 4'hA,
		ST_STOP_GRANT = 4'hB,
		ST_SG_SNOOP = 4'hC
	} lp_state_t;

	// Whole module state
	typedef struct packed {
		lp_state_t state;
		logic from_halt;
		logic smm;
		logic [`SG_CNT_W-1:0] cnt;
		logic [`EV_W-1:0] pend;
		logic ratio_low;
		logic vsel_low;
		logic [1:0] core_stop;
		logic sga_cycle;
		logic [`EV_W-1:0] deliver;
		logic snoop_active;
		logic stop_grant;
	} lp_regs_t;

	localparam lp_regs_t LP_RST = '{
		state: ST_NORMAL,
		from_halt: 1'b0,
		smm: 1'b0,
		cnt: `RST_CNT,
		pend: `RST_EVENTS,
		ratio_low: 1'b0,
		vsel_low: 1'b0,
		core_stop: `RST_CORES,
		sga_cycle: 1'b0,
		deliver: `RST_EVENTS,
		snoop_active: 1'b0,
		stop_grant: 1'b0
	};

endpackage

// file: pkg/lp_ctrl_regs.svh
// Constants for the core low-power state controller
`ifndef LP_CTRL_REGS_SVH
`define LP_CTRL_REGS_SVH

// -----------------------------------------------------------------
// Break event bit positions
// -----------------------------------------------------------------
`define EV_SMI 0
`define EV_WARM 1
`define EV_LINT0 2
`define EV_LINT1 3
`define EV_W 4

// -----------------------------------------------------------------
// Timing counts, in bus clocks
// -----------------------------------------------------------------
`define SG_DELAY_CLKS 5'h14
`define SG_CNT_W 5

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define RST_EVENTS 4'h0
`define RST_CORES 2'h0
`define RST_CNT 5'h00

`endif

// file: rtl/core_low_power_state_control.sv
// Low-power state controller: Normal, HALT, Extended HALT, Stop Grant, snoop states
`timescale 1ns/1ps
`include "lp_ctrl_regs.svh"

module core_low_power_state_control (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_sys_rst,
	// Core and firmware status
	input wire logic [1:0] i_core_idle,
	input wire logic i_ext_halt_en,
	input wire logic i_hw_restart,
	// Break events, one-cycle pulses, then handler return and its HALT resume select
	input wire logic i_smi,
	input wire logic i_warm_restart,
	input wire logic [1:0] i_local_int,
	input wire logic i_smi_return,
	input wire logic i_smi_resume_halt,
	// Clock-stop and bus cycles
	input wire logic i_clk_stop_req,
	input wire logic i_sga_resp,
	input wire logic i_snoop_req,
	input wire logic i_snoop_done,
	// Operating point steps
	input wire logic i_ratio_done,
	input wire logic i_vsel_done,
	// Status outputs
	output logic [3:0] o_state,
	output logic [1:0] o_core_stop,
	output logic o_ratio_low,
	output logic o_vsel_low,
	output logic o_sga_cycle,
	output logic o_snoop_active,
	output logic o_stop_grant,
	output logic o_smm_active,
	output logic [`EV_W-1:0] o_event_deliver
);

	// -----------------------------------------------------------------
	// State and helpers
	// -----------------------------------------------------------------
	lp_ctrl_pkg::lp_regs_t s_r;
	lp_ctrl_pkg::lp_regs_t s_nxt;
	logic [`EV_W-1:0] ev;
	logic brk;

	// Return to Normal, handing over every latched event exactly once
	function automatic lp_ctrl_pkg::lp_regs_t to_normal(input lp_ctrl_pkg::lp_regs_t x,
		input logic [`EV_W-1:0] e);
		lp_ctrl_pkg::lp_regs_t y;
		y = x;
		y.state = lp_ctrl_pkg::ST_NORMAL;
		y.deliver = x.pend | e;
		y.pend = `RST_EVENTS;
		y.smm = x.smm | x.pend[`EV_SMI] | e[`EV_SMI];
		return y;
	endfunction

	function automatic logic in_sg(input lp_ctrl_pkg::lp_state_t st);
		return (st == lp_ctrl_pkg::ST_SG_ACK) || (st == lp_ctrl_pkg::ST_SG_COUNT) ||
			(st == lp_ctrl_pkg::ST_STOP_GRANT) || (st == lp_ctrl_pkg::ST_SG_SNOOP);
	endfunction

	// Event vector and break condition
	assign ev = {i_local_int, i_warm_restart, i_smi};
	assign brk = |(ev | s_r.pend);

	// -----------------------------------------------------------------
	// Next-state logic
	// -----------------------------------------------------------------
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sga_cycle = 1'b0;
		s_nxt.deliver = `RST_EVENTS;
		// Outside Normal events wait, so a burst counts only once
		if (s_r.state != lp_ctrl_pkg::ST_NORMAL)
			s_nxt.pend = s_r.pend | ev;
		case (s_r.state)
			lp_ctrl_pkg::ST_NORMAL:
			begin
				if (ev[`EV_SMI])
					s_nxt.smm = 1'b1;
				if (s_r.smm && i_smi_return)
				begin
					s_nxt.smm = 1'b0;
					if (i_smi_resume_halt)
						s_nxt.state = lp_ctrl_pkg::ST_HALT;
				end
				else if (i_clk_stop_req)
				begin
					s_nxt.sga_cycle = 1'b1;
					s_nxt.from_halt = 1'b0;
					s_nxt.state = lp_ctrl_pkg::ST_SG_ACK;
				end
				else if (&i_core_idle)
				begin
					if (i_ext_halt_en)
					begin
						s_nxt.ratio_low = 1'b1;
						s_nxt.state = lp_ctrl_pkg::ST_XH_RATIO_DN;
					end
					else
						s_nxt.state = lp_ctrl_pkg::ST_HALT;
				end
			end
			lp_ctrl_pkg::ST_HALT:
			begin
				if (brk)
					s_nxt = to_normal(s_r, ev);
				else if (i_clk_stop_req)
				begin
					s_nxt.sga_cycle = 1'b1;
					s_nxt.from_halt = 1'b1;
					s_nxt.state = lp_ctrl_pkg::ST_SG_ACK;
				end
				else if (i_snoop_req)
					s_nxt.state = lp_ctrl_pkg::ST_HALT_SNOOP;
			end
			lp_ctrl_pkg::ST_HALT_SNOOP:
				if (i_snoop_done)
					s_nxt.state = lp_ctrl_pkg::ST_HALT;
			lp_ctrl_pkg::ST_XH_RATIO_DN:
				// Only the core ratio moves; the bus clock is never touched
				if (i_ratio_done)
				begin
					s_nxt.vsel_low = 1'b1;
					s_nxt.state = lp_ctrl_pkg::ST_XH_VSEL_DN;
				end
			lp_ctrl_pkg::ST_XH_VSEL_DN:
				if (i_vsel_done)
					s_nxt.state = lp_ctrl_pkg::ST_XHALT;
			lp_ctrl_pkg::ST_XHALT:
			begin
				if (brk)
				begin
					s_nxt.vsel_low = 1'b0;
					s_nxt.state = lp_ctrl_pkg::ST_XH_VSEL_UP;
				end
				else if (i_snoop_req)
					s_nxt.state = lp_ctrl_pkg::ST_XH_SNOOP;
			end
			lp_ctrl_pkg::ST_XH_SNOOP:
				if (i_snoop_done)
					s_nxt.state = lp_ctrl_pkg::ST_XHALT;
			lp_ctrl_pkg::ST_XH_VSEL_UP:
				if (i_vsel_done)
				begin
					s_nxt.ratio_low = 1'b0;
					s_nxt.state = lp_ctrl_pkg::ST_XH_RATIO_UP;
				end
			lp_ctrl_pkg::ST_XH_RATIO_UP:
				if (i_ratio_done)
					s_nxt = to_normal(s_r, ev);
			lp_ctrl_pkg::ST_SG_ACK:
				if (i_sga_resp)
				begin
					s_nxt.cnt = `SG_CNT_W'(1);
					s_nxt.state = lp_ctrl_pkg::ST_SG_COUNT;
				end
			lp_ctrl_pkg::ST_SG_COUNT:
			begin
				// Counted from the response phase seen in the acknowledge state
				if (s_r.cnt == (`SG_DELAY_CLKS - `SG_CNT_W'(1)))
				begin
					s_nxt.cnt = `RST_CNT;
					s_nxt.state = lp_ctrl_pkg::ST_STOP_GRANT;
				end
				else
					s_nxt.cnt = s_r.cnt + `SG_CNT_W'(1);
			end
			lp_ctrl_pkg::ST_STOP_GRANT:
			begin
				if (!i_clk_stop_req)
				begin
					if (s_r.from_halt)
						s_nxt.state = lp_ctrl_pkg::ST_HALT;
					else
						s_nxt = to_normal(s_r, ev);
					s_nxt.from_halt = 1'b0;
				end
				else if (i_snoop_req)
					s_nxt.state = lp_ctrl_pkg::ST_SG_SNOOP;
			end
			lp_ctrl_pkg::ST_SG_SNOOP:
				if (i_snoop_done)
					s_nxt.state = lp_ctrl_pkg::ST_STOP_GRANT;
			default:
				s_nxt = lp_ctrl_pkg::LP_RST;
		endcase
		// Restart reinitializes at once; Stop Grant itself is kept until clock-stop drops
		if (i_hw_restart)
		begin
			s_nxt.pend = `RST_EVENTS;
			s_nxt.deliver = `RST_EVENTS;
			s_nxt.smm = 1'b0;
			s_nxt.from_halt = 1'b0;
			if (!in_sg(s_r.state))
				s_nxt = lp_ctrl_pkg::LP_RST;
		end
		// Per-core stop: a lone halted core stops while the package stays Normal
		if (s_nxt.state == lp_ctrl_pkg::ST_NORMAL)
			s_nxt.core_stop = i_core_idle;
		else
			s_nxt.core_stop = 2'h3;
		s_nxt.snoop_active = (s_nxt.state == lp_ctrl_pkg::ST_HALT_SNOOP) ||
			(s_nxt.state == lp_ctrl_pkg::ST_XH_SNOOP) ||
			(s_nxt.state == lp_ctrl_pkg::ST_SG_SNOOP);
		s_nxt.stop_grant = (s_nxt.state == lp_ctrl_pkg::ST_STOP_GRANT);
	end

	// State register
	always_ff @(posedge i_ref_clk)
	begin
		if (i_sys_rst)
			s_r <= lp_ctrl_pkg::LP_RST;
		else
			s_r <= s_nxt;
	end

	// -----------------------------------------------------------------
	// Outputs, all straight from the state register
	// -----------------------------------------------------------------
	assign o_state = s_r.state;
	assign o_core_stop = s_r.core_stop;
	assign o_ratio_low = s_r.ratio_low;
	assign o_vsel_low = s_r.vsel_low;
	assign o_sga_cycle = s_r.sga_cycle;
	assign o_snoop_active = s_r.snoop_active;
	assign o_stop_grant = s_r.stop_grant;
	assign o_smm_active = s_r.smm;
	assign o_event_deliver = s_r.deliver;

	// -----------------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_quiet;
		!i_hw_restart && !i_clk_stop_req && !(s_r.smm && i_smi_return);
	endsequence
	sequence s_ratio_step;
		s_r.state == lp_ctrl_pkg::ST_XH_RATIO_DN && i_ratio_done && !i_hw_restart;
	endsequence
	sequence s_sga_seen;
		s_r.state == lp_ctrl_pkg::ST_SG_ACK && i_sga_resp;
	endsequence

	a_halt_default: assert property (((s_r.state == lp_ctrl_pkg::ST_NORMAL && &i_core_idle &&
		!i_ext_halt_en) and s_quiet) |=> s_r.state == lp_ctrl_pkg::ST_HALT)
		else $error("halt not taken as default powerdown");
	a_single_core: assert property (s_r.state == lp_ctrl_pkg::ST_NORMAL && !i_clk_stop_req &&
		!(s_r.smm && i_smi_return) && i_core_idle != 2'h3 |=>
		s_r.state == lp_ctrl_pkg::ST_NORMAL && o_core_stop == $past(i_core_idle))
		else $error("single halted core changed package state");
	a_break_halt: assert property (s_r.state == lp_ctrl_pkg::ST_HALT && !i_hw_restart &&
		brk |=> s_r.state == lp_ctrl_pkg::ST_NORMAL && o_event_deliver != `RST_EVENTS)
		else $error("break event did not leave halt");
	a_restart_init: assert property (i_hw_restart && !in_sg(s_r.state) |=>
		s_r.state == lp_ctrl_pkg::ST_NORMAL && !o_ratio_low && !o_vsel_low)
		else $error("restart did not initialize");
	a_smi_resume: assert property (s_r.state == lp_ctrl_pkg::ST_NORMAL && s_r.smm &&
		i_smi_return && !i_hw_restart |=> s_r.state ==
		($past(i_smi_resume_halt) ? lp_ctrl_pkg::ST_HALT : lp_ctrl_pkg::ST_NORMAL))
		else $error("handler return selection ignored");
	a_sg_to_halt: assert property (s_r.state == lp_ctrl_pkg::ST_STOP_GRANT && s_r.from_halt &&
		!i_clk_stop_req && !i_hw_restart |=> s_r.state == lp_ctrl_pkg::ST_HALT)
		else $error("clock-stop release did not resume halt");
	a_halt_snoop: assert property (s_r.state == lp_ctrl_pkg::ST_HALT && !i_hw_restart && !brk &&
		!i_clk_stop_req && i_snoop_req |=> o_snoop_active ##0 (!i_snoop_done && !i_hw_restart) [*1]
		|=> s_r.state == lp_ctrl_pkg::ST_HALT_SNOOP)
		else $error("snoop in halt not serviced");
	a_ratio_first: assert property (s_ratio_step |=> o_ratio_low && o_vsel_low &&
		s_r.state == lp_ctrl_pkg::ST_XH_VSEL_DN)
		else $error("voltage step out of order on entry");
	a_vsel_needs_ratio: assert property ($rose(o_vsel_low) |-> o_ratio_low)
		else $error("voltage lowered before ratio");
	a_vsel_first_exit: assert property ($fell(o_ratio_low) |-> !o_vsel_low)
		else $error("ratio restored before voltage");
	a_sg_delay: assert property (s_sga_seen |-> ##20 s_r.state == lp_ctrl_pkg::ST_STOP_GRANT)
		else $error("stop grant not entered twenty clocks after response");
	a_deliver_normal: assert property (o_event_deliver != `RST_EVENTS |->
		s_r.state == lp_ctrl_pkg::ST_NORMAL && $past(s_r.state) != lp_ctrl_pkg::ST_NORMAL)
		else $error("latched events delivered outside return to normal");
	a_snoop_return: assert property (s_r.state == lp_ctrl_pkg::ST_SG_SNOOP && i_snoop_done
		|=> s_r.state == lp_ctrl_pkg::ST_STOP_GRANT)
		else $error("snoop state did not return");

endmodule // core_low_power_state_control

// file: testbench/chipset_model.sv
// Behavioural chipset and operating point model facing the controller
`timescale 1ns/1ps

module chipset_model (
	// Clock and answer delay
	input wire logic i_clk,
	input wire logic [2:0] i_dly,
	// Controller status
	input wire logic i_sga,
	input wire logic i_rlow,
	input wire logic i_vlow,
	input wire logic i_snp,
	// Answers, one-cycle pulses
	output logic o_sga_resp,
	output logic o_ratio_done,
	output logic o_vsel_done,
	output logic o_snoop_done
);
	logic [3:0] trig;
	logic [3:0] ans = 4'h0;
	logic [2:0] prev_r = 3'h0;
	int cnt [4] = '{0, 0, 0, 0};

	// A step is answered only after the controller asked for it, i_dly + 1 cycles after it is seen
	assign trig = {i_snp & ~prev_r[2], i_vlow ^ prev_r[1], i_rlow ^ prev_r[0], i_sga};
	assign {o_snoop_done, o_vsel_done, o_ratio_done, o_sga_resp} = ans;

	// Inputs move on the falling edge, away from the controller's sampling edge
	always @(negedge i_clk)
	begin
		prev_r <= {i_snp, i_vlow, i_rlow};
		for (int k = 0; k < 4; k++)
		begin
			ans[k] <= (cnt[k] == 1);
			cnt[k] <= trig[k] ? int'(i_dly) + 1 : (cnt[k] > 0 ? cnt[k] - 1 : 0);
		end
	end
endmodule // chipset_model

// file: testbench/tb_top.sv
// Self-checking bench for the core low-power state controller
`timescale 1ns/1ps
`include "lp_ctrl_regs.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("FAIL %s exp %h got %h", nm, e, g); end end

module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [1:0] idle, cstp;
	logic xen, hwr, sret, sres, cstop, snq, sga_resp, rdone, vdone, sdone;
	logic [3:0] ev, st, dlv, last_st;
	logic rlow, vlow, sga, snp, sg, smm;
	logic [2:0] dly;
	logic [9:0] exp_q [$];
	logic [9:0] exp_n;
	logic [2:0] exp_f;
	int seed = 32'h3139_691c;
	int bad_count = 0;
	int n_checks = 0;
	int cyc = 0;
	int t_cnt = 0;

	// Bus clock, 100 MHz
	always #5 clk = ~clk;

	core_low_power_state_control i_core_low_power_state_control (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_core_idle(idle), .i_ext_halt_en(xen),
		.i_hw_restart(hwr), .i_smi(ev[0]), .i_warm_restart(ev[1]), .i_local_int(ev[3:2]),
		.i_smi_return(sret), .i_smi_resume_halt(sres), .i_clk_stop_req(cstop),
		.i_sga_resp(sga_resp), .i_snoop_req(snq), .i_snoop_done(sdone),
		.i_ratio_done(rdone), .i_vsel_done(vdone), .o_state(st), .o_core_stop(cstp),
		.o_ratio_low(rlow), .o_vsel_low(vlow), .o_sga_cycle(sga), .o_snoop_active(snp),
		.o_stop_grant(sg), .o_smm_active(smm), .o_event_deliver(dlv));

	chipset_model i_chipset_model (
		.i_clk(clk), .i_dly(dly), .i_sga(sga), .i_rlow(rlow), .i_vlow(vlow), .i_snp(snp),
		.o_sga_resp(sga_resp), .o_ratio_done(rdone), .o_vsel_done(vdone),
		.o_snoop_done(sdone));

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	task automatic note(input lp_ctrl_pkg::lp_state_t s, input logic [1:0] rv,
		input logic [3:0] d);
		exp_q.push_back({s, rv, d});
	endtask

	task automatic clks(input int n);
		repeat (n) @(negedge clk);
	endtask

	// Break events are one-cycle pulses
	task automatic pulse(input logic [3:0] e);
		ev = e;
		@(negedge clk);
		ev = 4'h0;
	endtask

	// Bounded wait for a state
	task automatic wait_st(input lp_ctrl_pkg::lp_state_t s);
		for (int k = 0; k < 200 && st !== s; k++)
			@(negedge clk);
		`CHK("reach state", s, st)
	endtask

	// Clock-stop round trip with a snoop and doubled events while stopped
	task automatic stop_grant(input lp_ctrl_pkg::lp_state_t back, input logic [3:0] e);
		note(lp_ctrl_pkg::ST_SG_ACK, 2'h0, 4'h0);
		note(lp_ctrl_pkg::ST_SG_COUNT, 2'h0, 4'h0);
		note(lp_ctrl_pkg::ST_STOP_GRANT, 2'h0, 4'h0);
		cstop = 1'b1;
		wait_st(lp_ctrl_pkg::ST_STOP_GRANT);
		note(lp_ctrl_pkg::ST_SG_SNOOP, 2'h0, 4'h0);
		note(lp_ctrl_pkg::ST_STOP_GRANT, 2'h0, 4'h0);
		snq = 1'b1;
		@(negedge clk);
		snq = 1'b0;
		wait_st(lp_ctrl_pkg::ST_STOP_GRANT);
		pulse(e);
		clks(1);
		pulse(e);
		note(back, 2'h0, (back == lp_ctrl_pkg::ST_NORMAL) ? e : 4'h0);
		cstop = 1'b0;
		clks(4);
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Monitor: each state change consumes the oldest note
	// ---------------------------------------------------------------
	always @(posedge clk)
	begin
		#1;
		cyc++;
		if (rst)
			last_st = st;
		else if (st !== last_st)
		begin
			exp_n = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
			`CHK("state note", exp_n, {st, rlow, vlow, dlv})
			// Acknowledge pulse, snoop flag and stop grant flag follow the new state
			exp_f[2] = (st === lp_ctrl_pkg::ST_SG_ACK);
			exp_f[1] = (st === lp_ctrl_pkg::ST_HALT_SNOOP) || (st === lp_ctrl_pkg::ST_XH_SNOOP) ||
				(st === lp_ctrl_pkg::ST_SG_SNOOP);
			exp_f[0] = (st === lp_ctrl_pkg::ST_STOP_GRANT);
			`CHK("status flags", exp_f, {sga, snp, sg})
			if (st === lp_ctrl_pkg::ST_SG_COUNT)
				t_cnt = cyc;
			if (st === lp_ctrl_pkg::ST_STOP_GRANT && last_st === lp_ctrl_pkg::ST_SG_COUNT)
				`CHK("stop grant delay", int'(`SG_DELAY_CLKS) - 1, cyc - t_cnt)
			last_st = st;
		end
		else if (dlv !== 4'h0)
			`CHK("stray delivery", 4'h0, dlv)
	end

	// Watchdog, far beyond the few hundred cycles the tests need
	initial
	begin
		#300us;
		bad_count++;
		conclude();
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		{idle, xen, hwr, ev, sret, sres, cstop, snq} = '0;
		dly = 3'h1;
		clks(2);
		rst = 1'b0;
		`CHK("reset state", 4'h0, st)
		idle = 2'h1 << ($random(seed) & 1);
		clks(3);
		`CHK("lone core stop", idle, cstp)
		`CHK("lone core state", 4'h0, st)
		$display("test lone_core done");
		for (int k = 0; k < 4; k++)
		begin
			note(lp_ctrl_pkg::ST_HALT, 2'h0, 4'h0);
			idle = 2'h3;
			wait_st(lp_ctrl_pkg::ST_HALT);
			note(lp_ctrl_pkg::ST_NORMAL, 2'h0, 4'h1 << (3 - k));
			pulse(4'h1 << (3 - k));
			idle = 2'h0;
			clks(2);
		end
		`CHK("handler active", 1'b1, smm)
		note(lp_ctrl_pkg::ST_HALT, 2'h0, 4'h0);
		{sres, sret} = 2'h3;
		@(negedge clk);
		sret = 1'b0;
		note(lp_ctrl_pkg::ST_HALT_SNOOP, 2'h0, 4'h0);
		note(lp_ctrl_pkg::ST_HALT, 2'h0, 4'h0);
		snq = 1'b1;
		@(negedge clk);
		snq = 1'b0;
		clks(10);
		$display("test halt done");
		dly = 3'h4;
		stop_grant(lp_ctrl_pkg::ST_HALT, 4'h0);
		note(lp_ctrl_pkg::ST_NORMAL, 2'h0, 4'h2);
		pulse(4'h2);
		stop_grant(lp_ctrl_pkg::ST_NORMAL, 4'h5);
		{sres, sret} = 2'h1;
		@(negedge clk);
		sret = 1'b0;
		clks(1);
		`CHK("handler left", 1'b0, smm)
		$display("test stop_grant done");
		xen = 1'b1;
		dly = 3'(1 + ($random(seed) & 3));
		note(lp_ctrl_pkg::ST_XH_RATIO_DN, 2'h2, 4'h0);
		note(lp_ctrl_pkg::ST_XH_VSEL_DN, 2'h3, 4'h0);
		note(lp_ctrl_pkg::ST_XHALT, 2'h3, 4'h0);
		note(lp_ctrl_pkg::ST_XH_SNOOP, 2'h3, 4'h0);
		note(lp_ctrl_pkg::ST_XHALT, 2'h3, 4'h0);
		note(lp_ctrl_pkg::ST_XH_VSEL_UP, 2'h2, 4'h0);
		note(lp_ctrl_pkg::ST_XH_RATIO_UP, 2'h0, 4'h0);
		note(lp_ctrl_pkg::ST_NORMAL, 2'h0, 4'h8);
		idle = 2'h3;
		wait_st(lp_ctrl_pkg::ST_XHALT);
		snq = 1'b1;
		@(negedge clk);
		snq = 1'b0;
		wait_st(lp_ctrl_pkg::ST_XHALT);
		pulse(4'h8);
		idle = 2'h0;
		wait_st(lp_ctrl_pkg::ST_NORMAL);
		$display("test ext_halt done");
		note(lp_ctrl_pkg::ST_XH_RATIO_DN, 2'h2, 4'h0);
		note(lp_ctrl_pkg::ST_XH_VSEL_DN, 2'h3, 4'h0);
		note(lp_ctrl_pkg::ST_NORMAL, 2'h0, 4'h0);
		idle = 2'h3;
		wait_st(lp_ctrl_pkg::ST_XH_VSEL_DN);
		hwr = 1'b1;
		idle = 2'h0;
		@(negedge clk);
		hwr = 1'b0;
		clks(6);
		`CHK("restart core stop", 2'h0, cstp)
		// Restart while stopped from HALT keeps Stop Grant, drops the event and the HALT return
		xen = 1'b0;
		note(lp_ctrl_pkg::ST_HALT, 2'h0, 4'h0);
		idle = 2'h3;
		wait_st(lp_ctrl_pkg::ST_HALT);
		idle = 2'h0;
		note(lp_ctrl_pkg::ST_SG_ACK, 2'h0, 4'h0);
		note(lp_ctrl_pkg::ST_SG_COUNT, 2'h0, 4'h0);
		note(lp_ctrl_pkg::ST_STOP_GRANT, 2'h0, 4'h0);
		cstop = 1'b1;
		wait_st(lp_ctrl_pkg::ST_STOP_GRANT);
		{hwr, ev} = 5'h11;
		@(negedge clk);
		{hwr, ev} = 5'h00;
		`CHK("restart keeps stop grant", lp_ctrl_pkg::ST_STOP_GRANT, st)
		note(lp_ctrl_pkg::ST_NORMAL, 2'h0, 4'h0);
		cstop = 1'b0;
		clks(4);
		`CHK("restart drops handler", 1'b0, smm)
		`CHK("notes left", 0, exp_q.size())
		$display("test restart done");
		conclude();
	end
endmodule // tb_top
